// >>> hw/eedc_pkg.sv
/*
  Constants, register layout and carrier types of the data EEPROM erase and program sequencer.
  Assumes a single system clock at CLK_MHZ and a Wishbone register bus with 32-bit data.
*/
package eedc_pkg;

  // ----------------------------------------------------------------
  // Array geometry and mapping
  // ----------------------------------------------------------------
  localparam int unsigned EE_WORDS      = 512;
  localparam int unsigned EE_AW         = 9;
  localparam int unsigned BLK_WORDS     = 16;
  localparam int unsigned BLK_AW        = 4;
  localparam logic [23:0] EE_BASE       = 24'h7FFC00;
  localparam int unsigned EE_TOP_LSB    = 10;
  localparam logic [15:0] ERASED_WORD   = 16'hFFFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PROG_TIME_US  = 2000;
  localparam int unsigned CLK_MHZ       = 10;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned WB_AW         = 13;
  localparam int unsigned IDX_W         = 11;
  localparam logic [10:0] IDX_CONTROL   = 11'h260;
  localparam logic [10:0] IDX_ADDR_LOW  = 11'h762;
  localparam logic [10:0] IDX_ADDR_UP   = 11'h764;
  localparam logic [10:0] IDX_KEY       = 11'h766;
  localparam logic [10:0] IDX_IRQ_FLAG  = 11'h768;

  // ----------------------------------------------------------------
  // Field values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'hAA;
  localparam logic [5:0]  OP_WORD       = 6'h04;
  localparam logic [5:0]  OP_BLOCK      = 6'h05;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] ADDR_RESET    = 16'h0000;
  localparam logic [7:0]  KEY_RESET     = 8'h00;
  localparam int unsigned DONE_BIT      = 0;

  typedef struct packed {
    logic       start;
    logic       allow;
    logic       fault;
    logic [5:0] rsvd;
    logic       erase;
    logic [5:0] op;
  } eedc_ctrl_t;

  typedef struct packed {
    logic        stb;
    logic        we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } eedc_tbl_req_t;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} eedc_key_t;

endpackage : eedc_pkg

// >>> hw/eedc_sequencer.sv
/*
  Data EEPROM erase and program sequencer: array, write latches, unlock logic, cycle timer and
  Wishbone classic register slave.
  Assumes table accesses and warm resets arrive synchronous to clk_i; rst_i is the power-up reset.
*/
// Behaviour
// RL1: Word and sixteen-word block operations supported.
// RL2: 512 words mapped from 0x7FFC00.
// RL3: Cycle time is a parameter, about 2 ms.
// RL4: Core is never stalled during a cycle.
// RL5: Reads during a cycle may be undefined.
// RL6: Software sets write_start; only hardware clears.
// RL7: Operations start only with write_allow; cleared at power-up.
// RL8: Hardware never clears write_allow itself.
// RL9: Interrupting reset sets write_fault, kept after.
// RL10: Interrupting reset keeps low address register.
// RL11: Cycle end clears write_start, sets done flag.
// RL12: Keys 0x55 then 0xAA, then write_start.
// RL13: write_start refused while write_allow clear.
// RL14: Same-write write_allow and write_start does not start.
// RL15: Clearing write_allow never disturbs running cycle.
// RL16: Control 0x4045 selects block erase.
// RL17: Control 0x4044 selects word erase.
// RL18: Control 0x4004 programs one word from latch.
// RL19: Table write loads address registers.
// RL20: Table read returns addressed stored word.
// RL21: Host erases before programming.
// RL22: Host waits for cycle end before next.
// RL23: Host keeps interrupts off during unlock.
// RL24: Control bits 15,14,13,6 and low opcode.
// RL25: Any other register write cancels unlock.
`timescale 1ns/1ps
module eedc_sequencer
  import eedc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               warm_reset_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire eedc_tbl_req_t      tbl_req_i,
  output logic      [15:0]        tbl_rdata_o,
  output logic                    tbl_ack_o
);

  localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int          CYC_LAST = PROG_CYCLES - 1;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic ee_hit(input logic [23:0] a);
    ee_hit = (a[23:EE_TOP_LSB] == EE_BASE[23:EE_TOP_LSB]);
  endfunction : ee_hit

  function automatic logic [EE_AW-1:0] ee_index(input logic [23:0] a);
    ee_index = a[EE_AW:1];
  endfunction : ee_index

  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] d,
                                             input logic [3:0] sel);
    lane_merge = {sel[1] ? d[15:8] : old_v[15:8], sel[0] ? d[7:0] : old_v[7:0]};
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [15:0]          mem     [EE_WORDS];
  logic [15:0]          latches [BLK_WORDS];
  eedc_ctrl_t           ctrl_reg;
  eedc_ctrl_t           ctrl_next;
  logic [15:0]          addr_low_reg;
  logic [7:0]           addr_up_reg;
  logic [7:0]           key_reg;
  logic                 done_flag_reg;
  eedc_key_t            key_state_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic                 op_erase_reg;
  logic                 op_block_reg;
  logic                 op_valid_reg;
  logic [EE_AW-1:0]     tgt_idx_reg;
  logic                 wb_ack_reg;
  logic [31:0]          wb_dat_reg;
  logic                 tbl_ack_reg;
  logic [15:0]          tbl_rdata_reg;

  logic                 commit;
  logic                 wr;
  logic [IDX_W-1:0]     reg_idx;
  logic                 wr_ctrl;
  logic                 start_ok;
  logic                 done_pulse;
  logic                 tbl_hit;
  logic [23:0]          target;

  assign commit     = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  assign wr         = commit & wb_we_i;
  assign reg_idx    = wb_adr_i[WB_AW-1:2];
  assign wr_ctrl    = wr & (reg_idx == IDX_CONTROL);
  assign tbl_hit    = tbl_req_i.stb & ee_hit(tbl_req_i.addr);
  assign target     = {addr_up_reg, addr_low_reg};
  assign done_pulse = ctrl_reg.start & (cnt_reg == CNT_W'(CYC_LAST));
  assign ctrl_next  = eedc_ctrl_t'(lane_merge(ctrl_reg, wb_dat_i, wb_sel_i));

  // A set of write_start needs the armed key and a write_allow already held before this write.
  // RL12 RL13 RL14 start qualification
  assign start_ok   = ctrl_next.start & ~ctrl_reg.start & ctrl_reg.allow & (key_state_reg == KEY_ARMED);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i)
    begin
      wb_ack_reg <= 1'b0;
    end
    else
    begin
      wb_ack_reg <= commit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i)
    begin
      wb_dat_reg <= 32'h00000000;
    end
    else if (commit && !wb_we_i)
    begin
      unique case (reg_idx)
        // RL24 control layout
        IDX_CONTROL:  wb_dat_reg <= {16'h0000, ctrl_reg.start, ctrl_reg.allow, ctrl_reg.fault, 6'h00,
                                     ctrl_reg.erase, ctrl_reg.op};
        IDX_ADDR_LOW: wb_dat_reg <= {16'h0000, addr_low_reg};
        IDX_ADDR_UP:  wb_dat_reg <= {24'h000000, addr_up_reg};
        IDX_KEY:      wb_dat_reg <= {24'h000000, key_reg};
        IDX_IRQ_FLAG: wb_dat_reg <= {31'h00000000, done_flag_reg};
        default:      wb_dat_reg <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Unlock key sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i)
    begin
      key_state_reg <= KEY_IDLE;
    end
    else if (wr)
    begin
      // RL12 key order
      if (reg_idx == IDX_KEY && wb_sel_i[0] && wb_dat_i[7:0] == KEY_FIRST)
      begin
        key_state_reg <= KEY_HALF;
      end
      else if (reg_idx == IDX_KEY && wb_sel_i[0] && wb_dat_i[7:0] == KEY_SECOND &&
               key_state_reg == KEY_HALF)
      begin
        key_state_reg <= KEY_ARMED;
      end
      else
      begin
        // RL25 unlock cancelled
        key_state_reg <= KEY_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i)
    begin
      key_reg <= KEY_RESET;
    end
    else if (wr && reg_idx == IDX_KEY && wb_sel_i[0])
    begin
      key_reg <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // RL7 power-up clear
      ctrl_reg <= eedc_ctrl_t'(CTRL_RESET);
    end
    else if (warm_reset_i)
    begin
      // RL9 interrupted write flagged
      ctrl_reg.fault <= ctrl_reg.fault | ctrl_reg.start;
      ctrl_reg.start <= 1'b0;
      ctrl_reg.erase <= 1'b0;
      ctrl_reg.op    <= 6'h00;
      ctrl_reg.rsvd  <= 6'h00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // RL8 allow changes only by software
        ctrl_reg.allow <= ctrl_next.allow;
        ctrl_reg.fault <= ctrl_reg.fault & ctrl_next.fault;
        ctrl_reg.erase <= ctrl_next.erase;
        ctrl_reg.op    <= ctrl_next.op;
      end
      // RL11 end clears start
      if (done_pulse)
      begin
        ctrl_reg.start <= 1'b0;
      end
      // RL6 software set only
      else if (wr_ctrl && start_ok)
      begin
        ctrl_reg.start <= 1'b1;
      end
    end
  end

  // The operation is frozen at start so later control writes cannot alter a running cycle.
  // RL15 RL16 RL17 RL18 operation capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_erase_reg <= 1'b0;
      op_block_reg <= 1'b0;
      op_valid_reg <= 1'b0;
      tgt_idx_reg  <= '0;
    end
    else if (wr_ctrl && start_ok)
    begin
      op_erase_reg <= ctrl_next.erase;
      op_block_reg <= (ctrl_next.op == OP_BLOCK);
      op_valid_reg <= ee_hit(target) && (ctrl_next.op == OP_BLOCK || ctrl_next.op == OP_WORD);
      tgt_idx_reg  <= ee_index(target);
    end
  end

  // ----------------------------------------------------------------
  // Cycle timer
  // ----------------------------------------------------------------
  // The duration is a parameter only; real parts vary with supply and temperature.
  // RL3 cycle duration
  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i || !ctrl_reg.start || done_pulse)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i)
    begin
      done_flag_reg <= 1'b0;
    end
    // RL11 done flag set wins
    else if (done_pulse)
    begin
      done_flag_reg <= 1'b1;
    end
    else if (wr && reg_idx == IDX_IRQ_FLAG && wb_sel_i[0])
    begin
      done_flag_reg <= wb_dat_i[DONE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Address registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_low_reg <= ADDR_RESET;
      addr_up_reg  <= 8'h00;
    end
    // RL10 address survives warm reset
    else if (warm_reset_i)
    begin
      addr_low_reg <= addr_low_reg;
    end
    // RL19 table write captures address
    else if (tbl_hit && tbl_req_i.we)
    begin
      addr_low_reg <= tbl_req_i.addr[15:0];
      addr_up_reg  <= tbl_req_i.addr[23:16];
    end
    else if (wr && reg_idx == IDX_ADDR_LOW)
    begin
      addr_low_reg <= lane_merge(addr_low_reg, wb_dat_i, wb_sel_i);
    end
    else if (wr && reg_idx == IDX_ADDR_UP && wb_sel_i[0])
    begin
      addr_up_reg <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Array and write latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (tbl_hit && tbl_req_i.we)
    begin
      latches[tbl_req_i.addr[BLK_AW:1]] <= tbl_req_i.wdata;
    end
  end

  // RL1 RL2 word and block update
  always_ff @(posedge clk_i)
  begin
    // A warm reset in the last cycle aborts the operation, so the array stays untouched.
    if (done_pulse && op_valid_reg && !warm_reset_i)
    begin
      for (int i = 0; i < BLK_WORDS; i++)
      begin
        if (op_block_reg || BLK_AW'(i) == tgt_idx_reg[BLK_AW-1:0])
        begin
          mem[{tgt_idx_reg[EE_AW-1:BLK_AW], BLK_AW'(i)}] <= op_erase_reg ? ERASED_WORD : latches[i];
        end
      end
    end
  end

  // Reads are never held off during a cycle, so data returned then is not guaranteed.
  // RL4 RL5 RL20 table answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || warm_reset_i)
    begin
      tbl_ack_reg   <= 1'b0;
      tbl_rdata_reg <= 16'h0000;
    end
    else
    begin
      tbl_ack_reg   <= tbl_req_i.stb;
      tbl_rdata_reg <= (tbl_hit && !tbl_req_i.we) ? mem[ee_index(tbl_req_i.addr)] : 16'h0000;
    end
  end

  assign wb_ack_o    = wb_ack_reg;
  assign wb_dat_o    = wb_dat_reg;
  assign tbl_ack_o   = tbl_ack_reg;
  assign tbl_rdata_o = tbl_rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_key_armed: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    $rose(ctrl_reg.start) |-> $past(key_state_reg) == KEY_ARMED && $past(wr_ctrl))
    else $error("Cycle started without the armed key.");

  a_start_prior_allow: assert property (@(posedge clk_i) disable iff (rst_i) // RL13 RL14
    $rose(ctrl_reg.start) |-> $past(ctrl_reg.allow))
    else $error("Cycle started without earlier write_allow.");

  a_start_held_on: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    ctrl_reg.start && !done_pulse && !warm_reset_i |=> ctrl_reg.start)
    else $error("write_start dropped before cycle end.");

  a_end_sets_done: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    done_pulse && !warm_reset_i |=> !ctrl_reg.start && done_flag_reg)
    else $error("Cycle end did not clear start and set done.");

  a_cycle_length: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    $fell(ctrl_reg.start) && !$past(warm_reset_i) |-> $past(cnt_reg) == CNT_W'(CYC_LAST))
    else $error("Cycle length differs from the programmed count.");

  a_allow_kept: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    $past(ctrl_reg.allow) && !$past(wr_ctrl) |-> ctrl_reg.allow)
    else $error("write_allow cleared by hardware.");

  a_fault_on_abort: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    warm_reset_i && ctrl_reg.start |=> ctrl_reg.fault && !ctrl_reg.start)
    else $error("Interrupted cycle did not set write_fault.");

  a_addr_kept_warm: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
    warm_reset_i |=> addr_low_reg == $past(addr_low_reg))
    else $error("Low address changed by warm reset.");

  a_tbl_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
    tbl_hit && tbl_req_i.we && !warm_reset_i |=> target == $past(tbl_req_i.addr))
    else $error("Table write address not captured.");

  a_tbl_no_stall: assert property (@(posedge clk_i) disable iff (rst_i || warm_reset_i) // RL4
    tbl_req_i.stb |=> tbl_ack_reg)
    else $error("Table access not answered next cycle.");

  a_unlock_cancel: assert property (@(posedge clk_i) disable iff (rst_i) // RL25
    wr && reg_idx != IDX_KEY |=> key_state_reg == KEY_IDLE)
    else $error("Unlock survived a foreign register write.");

endmodule : eedc_sequencer

// >>> verification/eedc_core_model.sv
/*
  Core model: issues Wishbone register cycles and table accesses to the sequencer.
  Assumes the sequencer answers both ports with a registered one-cycle ack.
*/
`timescale 1ns/1ps
module eedc_core_model
  import eedc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             wb_ack_i,
  output logic                  wb_cyc_o,
  output logic                  wb_stb_o,
  output logic                  wb_we_o,
  output logic      [WB_AW-1:0] wb_adr_o,
  output logic      [3:0]       wb_sel_o,
  output logic      [31:0]      wb_dat_o,
  output eedc_tbl_req_t         tbl_req_o
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = '0;
    wb_sel_o = 4'h0;
    wb_dat_o = '0;
    tbl_req_o = '0;
  end

  // ----------------------------------------------------------------
  // Register cycles
  // ----------------------------------------------------------------
  // Released address and data lines show inverted values so that a stale request is never read as a live one.
  task automatic wb_cycle(input logic we, input logic [IDX_W-1:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_sel_o <= 4'h3;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask : wb_cycle

  task automatic unlock(input logic [15:0] ctrl);
    wb_cycle(1'b1, IDX_KEY, {24'h0, KEY_FIRST});
    wb_cycle(1'b1, IDX_KEY, {24'h0, KEY_SECOND});
    wb_cycle(1'b1, IDX_CONTROL, {16'h0, ctrl});
  endtask : unlock

  // ----------------------------------------------------------------
  // Table accesses
  // ----------------------------------------------------------------
  task automatic tbl_access(input logic we, input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_i);
    tbl_req_o <= '{1'b1, we, a, d};
    @(posedge clk_i);
    tbl_req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask : tbl_access
endmodule : eedc_core_model

// >>> verification/eedc_tb.sv
/*
  Self-checking testbench of the erase and program sequencer with one queue of expected answers per port.
  Assumes the sequencer and the core model share one 10 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import eedc_pkg::*;
;
  localparam int unsigned PROG = 20;
  typedef struct {
    logic [31:0] m;
    logic [31:0] e;
    string       n;
  } eedc_exp_t;

  logic                   clk_i;
  logic                   rst_i;
  logic                   warm_reset_i;
  logic                   wb_cyc;
  logic                   wb_stb;
  logic                   wb_we;
  logic       [WB_AW-1:0] wb_adr;
  logic       [3:0]       wb_sel;
  logic       [31:0]      wb_dat;
  logic       [31:0]      wb_rdat;
  logic                   wb_ack;
  eedc_tbl_req_t          tbl_req;
  logic       [15:0]      tbl_rdata;
  logic                   tbl_ack;
  eedc_exp_t              wb_q[$];
  eedc_exp_t              tbl_q[$];
  int                     errors;
  int                     n_compared;
  int                     seed;
  logic       [31:0]      rnd;
  logic       [23:0]      addr_a;
  logic       [23:0]      addr_c;
  logic       [15:0]      data_d;
  int                     i;

  eedc_sequencer #(.PROG_CYCLES(PROG)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .warm_reset_i(warm_reset_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .tbl_req_i(tbl_req), .tbl_rdata_o(tbl_rdata), .tbl_ack_o(tbl_ack));

  eedc_core_model core (
    .clk_i(clk_i), .wb_ack_i(wb_ack), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat), .tbl_req_o(tbl_req));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Drivers, checker and verdict
  // ----------------------------------------------------------------
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] e, input string n);
    wb_q.push_back('{32'h0000FFFF, {16'h0, e}, n});
    core.wb_cycle(1'b0, idx, 32'h0);
  endtask : rd

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
    core.wb_cycle(1'b1, idx, {16'h0, d});
  endtask : wr

  task automatic tr(input logic [23:0] a, input logic [15:0] e, input logic [15:0] m);
    tbl_q.push_back('{{16'h0, m}, {16'h0, e}, "table read"});
    core.tbl_access(1'b0, a, 16'h0);
  endtask : tr

  task automatic tw(input logic [23:0] a, input logic [15:0] d);
    tbl_q.push_back('{32'h0, 32'h0, "table write"});
    core.tbl_access(1'b1, a, d);
  endtask : tw

  task automatic check(input eedc_exp_t x, input logic [31:0] seen);
    n_compared++;
    if ((seen & x.m) !== x.e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", x.n, x.e, seen & x.m);
    end
  endtask : check

  // Register writes are not compared, so only register read acks take a note off wb_q; every table ack takes one off tbl_q.
  always @(posedge clk_i)
  begin
    if (wb_ack === 1'b1 && wb_we !== 1'b1)
      check(wb_q.pop_front(), wb_rdat);
    if (tbl_ack === 1'b1)
      check(tbl_q.pop_front(), {16'h0, tbl_rdata});
  end

  task automatic test_done;
    if (wb_q.size() != 0 || tbl_q.size() != 0)
      errors++;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    n_compared = 0;
    seed = 11317;
    rst_i = 1'b1;
    warm_reset_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_CONTROL, CTRL_RESET, "control");
    rd(11'h001, 16'h0000, "unmapped");
    core.unlock(16'hC044);
    rd(IDX_CONTROL, 16'h4044, "control");
    wr(IDX_KEY, 16'h00AA);
    wr(IDX_KEY, 16'h0055);
    wr(IDX_CONTROL, 16'hC044);
    rd(IDX_CONTROL, 16'h4044, "control");
    wr(IDX_KEY, 16'h0055);
    wr(IDX_IRQ_FLAG, 16'h0000);
    wr(IDX_KEY, 16'h00AA);
    wr(IDX_CONTROL, 16'hC044);
    rd(IDX_CONTROL, 16'h4044, "control");
    rnd = $random(seed);
    addr_a = EE_BASE + {14'h0, rnd[8:0], 1'b0};
    tw(addr_a, rnd[31:16]);
    rd(IDX_ADDR_LOW, addr_a[15:0], "address low");
    rd(IDX_ADDR_UP, {8'h0, addr_a[23:16]}, "address upper");
    core.unlock(16'hC044);
    wr(IDX_CONTROL, 16'h4044);
    rd(IDX_CONTROL, 16'hC044, "control");
    tr(addr_a, 16'h0000, 16'h0000);
    repeat (PROG) @(posedge clk_i);
    rd(IDX_CONTROL, 16'h4044, "control");
    rd(IDX_IRQ_FLAG, 16'h0001, "done flag");
    wr(IDX_IRQ_FLAG, 16'h0000);
    rd(IDX_IRQ_FLAG, 16'h0000, "done flag");
    tr(addr_a, ERASED_WORD, 16'hFFFF);
    data_d = 16'($random(seed));
    tw(addr_a, data_d);
    wr(IDX_CONTROL, 16'h4004);
    core.unlock(16'hC004);
    wr(IDX_CONTROL, 16'h0004);
    rd(IDX_CONTROL, 16'h8004, "control");
    repeat (PROG) @(posedge clk_i);
    rd(IDX_CONTROL, 16'h0004, "control");
    tr(addr_a, data_d, 16'hFFFF);
    tw({addr_a[23:5], ~addr_a[4:1], 1'b0}, data_d);
    wr(IDX_CONTROL, 16'h4045);
    core.unlock(16'hC045);
    repeat (PROG) @(posedge clk_i);
    tr(addr_a, ERASED_WORD, 16'hFFFF);
    // block program into the erased block
    for (i = 0; i < BLK_WORDS; i++)
    begin
      tw({addr_a[23:5], 4'(i), 1'b0}, data_d ^ 16'(i));
    end
    wr(IDX_CONTROL, 16'h4005);
    core.unlock(16'hC005);
    repeat (PROG) @(posedge clk_i);
    tr(addr_a, data_d ^ {12'h000, addr_a[4:1]}, 16'hFFFF);
    rnd = $random(seed);
    addr_c = EE_BASE + {14'h0, rnd[8:0], 1'b0};
    tw(addr_c, rnd[31:16]);
    core.unlock(16'hC044);
    repeat (3) @(posedge clk_i);
    warm_reset_i <= 1'b1;
    @(posedge clk_i);
    warm_reset_i <= 1'b0;
    rd(IDX_CONTROL, 16'h6000, "control");
    rd(IDX_ADDR_LOW, addr_c[15:0], "address low");
    wr(IDX_CONTROL, 16'h4000);
    rd(IDX_CONTROL, 16'h4000, "control");
    repeat (4) @(posedge clk_i);
    test_done();
  end
endmodule : testbench
